// file: tsom_cfg.svh
// What this block does
// - polarity bit per pin, set means active low
// - drive-style bit: push-pull or drive-when-asserted only
// - pin zero drives only when its enable bit set
// - pin one drives only when aux enable bit set
// - select register holds two 5-bit source fields
// - any source on either pin, both allowed
// - code 01 routes the device interrupt
// - code 02 is the enabled-slots sample window
// - codes 05/06/07 copy slot A/B/both LED pulses
// - codes 0C/0D/0E flag slot A/B/either data written
// - written flag sets on data store, clears at next sample start
// - code 0F toggles once per sample period
// - half-rate starts low leaving standby, high after sample
// - codes 10/11 give constant logic 0/1
// - code 13 copies the 32 kHz oscillator
// - sample timing from 32 kHz, pulses from 32 MHz
`ifndef TSOM_CFG_SVH
`define TSOM_CFG_SVH

`define TSOM_ADDR_W 8
`define TSOM_DATA_W 16
`define TSOM_SEL_W 5

`define TSOM_ADDR_PIN_DRIVE 8'h02
`define TSOM_ADDR_PIN_SELECT 8'h0B
`define TSOM_ADDR_AUX_DRIVE 8'h4F

`define TSOM_CFG_POL0 0
`define TSOM_CFG_OD0 1
`define TSOM_CFG_EN0 2
`define TSOM_CFG_POL1 8
`define TSOM_CFG_OD1 9
`define TSOM_AUX_EN1 6

`define TSOM_SEL0_LSB 0
`define TSOM_SEL1_LSB 8

`define TSOM_RST_PIN_DRIVE 16'h0000
`define TSOM_RST_PIN_SELECT 16'h0000
`define TSOM_RST_AUX_DRIVE 16'h0000
`define TSOM_RDATA_NONE 16'h0000

`endif

// file: tsom_pkg.sv
package tsom_pkg;

  typedef enum logic [4:0] {
    TSOM_SEL_OFF = 5'h00,
    TSOM_SEL_IRQ = 5'h01,
    TSOM_SEL_WINDOW = 5'h02,
    TSOM_SEL_LED_A = 5'h05,
    TSOM_SEL_LED_B = 5'h06,
    TSOM_SEL_LED_AB = 5'h07,
    TSOM_SEL_WR_A = 5'h0C,
    TSOM_SEL_WR_B = 5'h0D,
    TSOM_SEL_WR_AB = 5'h0E,
    TSOM_SEL_HALF = 5'h0F,
    TSOM_SEL_LOGIC0 = 5'h10,
    TSOM_SEL_LOGIC1 = 5'h11,
    TSOM_SEL_OSC = 5'h13
  } tsom_sel_t;

  typedef enum logic [0:0] {
    TSOM_WIN_IDLE = 1'h0,
    TSOM_WIN_OPEN = 1'h1
  } tsom_win_state_t;

  // asserted level of the chosen source, before polarity
  function automatic logic tsom_select(input logic [4:0] code, input logic irq,
                                       input logic win, input logic led_a,
                                       input logic led_b, input logic wr_a,
                                       input logic wr_b, input logic half,
                                       input logic osc);
    logic v;
    v = 1'b0;
    case (code)
      TSOM_SEL_IRQ: v = irq;
      TSOM_SEL_WINDOW: v = win;
      TSOM_SEL_LED_A: v = led_a;
      TSOM_SEL_LED_B: v = led_b;
      TSOM_SEL_LED_AB: v = led_a | led_b;
      TSOM_SEL_WR_A: v = wr_a;
      TSOM_SEL_WR_B: v = wr_b;
      TSOM_SEL_WR_AB: v = wr_a | wr_b;
      TSOM_SEL_HALF: v = half;
      TSOM_SEL_LOGIC0: v = 1'b0;
      TSOM_SEL_LOGIC1: v = 1'b1;
      TSOM_SEL_OSC: v = osc;
      default: v = 1'b0;
    endcase
    return v;
  endfunction

endpackage

// file: tsom_pin_drive.sv
`timescale 1ns/1ps
module tsom_pin_drive
  import tsom_pkg::*;
(
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic asserted_i,
  input wire logic polarity_low_i,
  input wire logic open_drain_i,
  input wire logic drive_en_i,
  output logic pin_o,
  output logic pin_oe_n_o
);

  logic pin_nxt;
  logic oe_n_nxt;

  always_comb begin
    pin_nxt = asserted_i ^ polarity_low_i;
    // open drain lets go of the line whenever the source is idle
    oe_n_nxt = !(drive_en_i && (!open_drain_i || asserted_i));
  end

  // one flop stage: a selector change gives one clean edge at most
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      pin_o <= 1'b0;
      pin_oe_n_o <= 1'b1;
    end else begin
      pin_o <= pin_nxt;
      pin_oe_n_o <= oe_n_nxt;
    end
  end

endmodule

// file: tsom_half_rate.sv
`timescale 1ns/1ps
module tsom_half_rate
  import tsom_pkg::*;
(
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic normal_mode_i,
  input wire logic sample_done_i,
  output logic level_o
);

  logic normal_prev_r;
  logic level_nxt;

  always_comb begin
    if (!normal_mode_i || !normal_prev_r) begin
      level_nxt = 1'b0;
    end else if (sample_done_i) begin
      level_nxt = !level_o;
    end else begin
      level_nxt = level_o;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      normal_prev_r <= 1'b0;
      level_o <= 1'b0;
    end else begin
      normal_prev_r <= normal_mode_i;
      level_o <= level_nxt;
    end
  end

endmodule

// file: tsom_timing_mux.sv
`timescale 1ns/1ps
`include "tsom_cfg.svh"
module tsom_timing_mux
  import tsom_pkg::*;
(
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic [`TSOM_ADDR_W-1:0] reg_addr_i,
  input wire logic [`TSOM_DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [`TSOM_DATA_W-1:0] reg_rdata_o,
  input wire logic irq_i,
  input wire logic slot_a_en_i,
  input wire logic slot_b_en_i,
  input wire logic slot_a_start_i,
  input wire logic slot_a_end_i,
  input wire logic slot_b_start_i,
  input wire logic slot_b_end_i,
  input wire logic led_pulse_a_i,
  input wire logic led_pulse_b_i,
  input wire logic data_wr_a_i,
  input wire logic data_wr_b_i,
  input wire logic normal_mode_i,
  input wire logic osc32k_i,
  output logic timing_pin_zero_o,
  output logic timing_pin_zero_oe_n_o,
  output logic timing_pin_one_o,
  output logic timing_pin_one_oe_n_o
);

  logic [`TSOM_DATA_W-1:0] pin_drive_config_r;
  logic [`TSOM_DATA_W-1:0] pin_signal_select_r;
  logic [`TSOM_DATA_W-1:0] aux_pin_drive_enable_r;
  logic [`TSOM_DATA_W-1:0] rdata_nxt;

  tsom_win_state_t win_state_r;
  tsom_win_state_t win_state_nxt;
  logic win_start;
  logic win_end;
  logic sample_done;

  logic written_a_r;
  logic written_b_r;
  logic half_level;

  logic [`TSOM_SEL_W-1:0] sel_zero;
  logic [`TSOM_SEL_W-1:0] sel_one;
  logic asserted_zero;
  logic asserted_one;
  logic window_level;

  // register writes
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      pin_drive_config_r <= `TSOM_RST_PIN_DRIVE;
      pin_signal_select_r <= `TSOM_RST_PIN_SELECT;
      aux_pin_drive_enable_r <= `TSOM_RST_AUX_DRIVE;
    end else if (reg_wr_i) begin
      case (reg_addr_i)
        `TSOM_ADDR_PIN_DRIVE: pin_drive_config_r <= reg_wdata_i;
        `TSOM_ADDR_PIN_SELECT: pin_signal_select_r <= reg_wdata_i;
        `TSOM_ADDR_AUX_DRIVE: aux_pin_drive_enable_r <= reg_wdata_i;
        default: begin
        end
      endcase
    end
  end

  // register reads; unmapped addresses answer zero
  always_comb begin
    case (reg_addr_i)
      `TSOM_ADDR_PIN_DRIVE: rdata_nxt = pin_drive_config_r;
      `TSOM_ADDR_PIN_SELECT: rdata_nxt = pin_signal_select_r;
      `TSOM_ADDR_AUX_DRIVE: rdata_nxt = aux_pin_drive_enable_r;
      default: rdata_nxt = `TSOM_RDATA_NONE;
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      reg_rdata_o <= `TSOM_RDATA_NONE;
    end else if (reg_rd_i) begin
      reg_rdata_o <= rdata_nxt;
    end
  end

  // slot strobes arrive already timed by the 32 kHz and 32 MHz bases
  // and are sampled here as plain synchronous inputs
  always_comb begin
    win_start = slot_a_en_i ? slot_a_start_i : (slot_b_en_i && slot_b_start_i);
    win_end = slot_b_en_i ? slot_b_end_i : (slot_a_en_i && slot_a_end_i);
  end

  // sample window: open on the first enabled slot, shut on the last
  always_comb begin
    case (win_state_r)
      TSOM_WIN_IDLE: begin
        win_state_nxt = win_start ? TSOM_WIN_OPEN : TSOM_WIN_IDLE;
      end
      TSOM_WIN_OPEN: begin
        win_state_nxt = win_end ? TSOM_WIN_IDLE : TSOM_WIN_OPEN;
      end
      default: begin
        win_state_nxt = TSOM_WIN_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      win_state_r <= TSOM_WIN_IDLE;
    end else begin
      win_state_r <= win_state_nxt;
    end
  end

  assign window_level = (win_state_r == TSOM_WIN_OPEN);
  assign sample_done = win_end && window_level;

  // data-written flags; a store landing on a sample start is kept
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      written_a_r <= 1'b0;
    end else if (data_wr_a_i) begin
      written_a_r <= 1'b1;
    end else if (win_start) begin
      written_a_r <= 1'b0;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      written_b_r <= 1'b0;
    end else if (data_wr_b_i) begin
      written_b_r <= 1'b1;
    end else if (win_start) begin
      written_b_r <= 1'b0;
    end
  end

  tsom_half_rate u_half_rate (
    .clock_i(clock_i),
    .resetn_i(resetn_i),
    .normal_mode_i(normal_mode_i),
    .sample_done_i(sample_done),
    .level_o(half_level)
  );

  assign sel_zero = pin_signal_select_r[`TSOM_SEL0_LSB +: `TSOM_SEL_W];
  assign sel_one = pin_signal_select_r[`TSOM_SEL1_LSB +: `TSOM_SEL_W];

  // both pins see the same source set, so any code works on either pin
  always_comb begin
    asserted_zero = tsom_select(sel_zero, irq_i, window_level, led_pulse_a_i,
                                led_pulse_b_i, written_a_r, written_b_r,
                                half_level, osc32k_i);
    asserted_one = tsom_select(sel_one, irq_i, window_level, led_pulse_a_i,
                               led_pulse_b_i, written_a_r, written_b_r,
                               half_level, osc32k_i);
  end

  tsom_pin_drive u_pin_zero (
    .clock_i(clock_i),
    .resetn_i(resetn_i),
    .asserted_i(asserted_zero),
    .polarity_low_i(pin_drive_config_r[`TSOM_CFG_POL0]),
    .open_drain_i(pin_drive_config_r[`TSOM_CFG_OD0]),
    .drive_en_i(pin_drive_config_r[`TSOM_CFG_EN0]),
    .pin_o(timing_pin_zero_o),
    .pin_oe_n_o(timing_pin_zero_oe_n_o)
  );

  tsom_pin_drive u_pin_one (
    .clock_i(clock_i),
    .resetn_i(resetn_i),
    .asserted_i(asserted_one),
    .polarity_low_i(pin_drive_config_r[`TSOM_CFG_POL1]),
    .open_drain_i(pin_drive_config_r[`TSOM_CFG_OD1]),
    .drive_en_i(aux_pin_drive_enable_r[`TSOM_AUX_EN1]),
    .pin_o(timing_pin_one_o),
    .pin_oe_n_o(timing_pin_one_oe_n_o)
  );

  default clocking cb @(posedge clock_i);
  endclocking

  default disable iff (!resetn_i);

  a_pin0_polarity: assert property (
    (sel_zero == TSOM_SEL_LOGIC1) |=>
      (timing_pin_zero_o == !$past(pin_drive_config_r[`TSOM_CFG_POL0])))
    else $error("pin zero level ignores polarity");

  a_pin1_polarity: assert property (
    (sel_one == TSOM_SEL_LOGIC0) |=>
      (timing_pin_one_o == $past(pin_drive_config_r[`TSOM_CFG_POL1])))
    else $error("pin one level ignores polarity");

  a_od_release: assert property (
    (pin_drive_config_r[`TSOM_CFG_OD0] && pin_drive_config_r[`TSOM_CFG_EN0]
     && sel_zero == TSOM_SEL_LOGIC0) |=> timing_pin_zero_oe_n_o)
    else $error("open drain pin zero drives while idle");

  a_pushpull_drive: assert property (
    (!pin_drive_config_r[`TSOM_CFG_OD0] && pin_drive_config_r[`TSOM_CFG_EN0])
      |=> !timing_pin_zero_oe_n_o)
    else $error("push-pull pin zero not driving");

  a_pin0_disable: assert property (
    !pin_drive_config_r[`TSOM_CFG_EN0] |=> timing_pin_zero_oe_n_o)
    else $error("pin zero drives while disabled");

  a_pin1_disable: assert property (
    !aux_pin_drive_enable_r[`TSOM_AUX_EN1] |=> timing_pin_one_oe_n_o)
    else $error("pin one drives while disabled");

  a_select_write: assert property (
    (reg_wr_i && reg_addr_i == `TSOM_ADDR_PIN_SELECT) |=>
      (sel_one == $past(reg_wdata_i[`TSOM_SEL1_LSB +: `TSOM_SEL_W])
       && sel_zero == $past(reg_wdata_i[`TSOM_SEL0_LSB +: `TSOM_SEL_W])))
    else $error("select fields not taken from write");

  a_irq_route: assert property (
    (sel_zero == TSOM_SEL_IRQ && !pin_drive_config_r[`TSOM_CFG_POL0])
      |=> (timing_pin_zero_o == $past(irq_i)))
    else $error("interrupt not routed to pin zero");

  a_window_open: assert property (
    (win_state_r == TSOM_WIN_IDLE && win_start) |=> window_level)
    else $error("window did not open at first slot");

  a_window_close: assert property (
    (window_level && win_end) |=> !window_level)
    else $error("window did not close at last slot");

  a_written_hold: assert property (
    data_wr_a_i |=> written_a_r)
    else $error("slot A written flag not set");

  a_written_clear: assert property (
    (win_start && !data_wr_b_i) |=> !written_b_r)
    else $error("slot B written flag not cleared at sample start");

  a_half_start: assert property (
    (normal_mode_i && !$past(normal_mode_i)) |=> !half_level)
    else $error("half-rate did not start low");

  a_half_toggle: assert property (
    ($past(normal_mode_i) && normal_mode_i && sample_done) |=>
      (half_level != $past(half_level)))
    else $error("half-rate did not toggle at sample end");

  a_undef_idle: assert property (
    (sel_zero == TSOM_SEL_OFF) |=>
      (timing_pin_zero_o == $past(pin_drive_config_r[`TSOM_CFG_POL0])))
    else $error("undefined code does not idle pin zero");

  a_osc_copy: assert property (
    (sel_one == TSOM_SEL_OSC && !pin_drive_config_r[`TSOM_CFG_POL1])
      |=> (timing_pin_one_o == $past(osc32k_i)))
    else $error("oscillator not copied to pin one");

  a_pin0_led_a: assert property (
    (sel_zero == TSOM_SEL_LED_A && !pin_drive_config_r[`TSOM_CFG_POL0])
      |=> (timing_pin_zero_o == $past(led_pulse_a_i)))
    else $error("slot A pulses not copied to pin zero");

  a_pin1_led_b: assert property (
    (sel_one == TSOM_SEL_LED_B && !pin_drive_config_r[`TSOM_CFG_POL1])
      |=> (timing_pin_one_o == $past(led_pulse_b_i)))
    else $error("slot B pulses not copied to pin one");

  a_pin0_led_both: assert property (
    (sel_zero == TSOM_SEL_LED_AB && !pin_drive_config_r[`TSOM_CFG_POL0])
      |=> (timing_pin_zero_o == $past(led_pulse_a_i || led_pulse_b_i)))
    else $error("combined pulses not copied to pin zero");

  a_pin0_written_b: assert property (
    (sel_zero == TSOM_SEL_WR_B && !pin_drive_config_r[`TSOM_CFG_POL0])
      |=> (timing_pin_zero_o == $past(written_b_r)))
    else $error("slot B written flag not on pin zero");

  a_pin1_written_any: assert property (
    (sel_one == TSOM_SEL_WR_AB && !pin_drive_config_r[`TSOM_CFG_POL1])
      |=> (timing_pin_one_o == $past(written_a_r || written_b_r)))
    else $error("either-slot written flag not on pin one");

  a_pin0_window: assert property (
    (sel_zero == TSOM_SEL_WINDOW && !pin_drive_config_r[`TSOM_CFG_POL0])
      |=> (timing_pin_zero_o == $past(window_level)))
    else $error("sample window not on pin zero");

  a_pin1_half: assert property (
    (sel_one == TSOM_SEL_HALF && !pin_drive_config_r[`TSOM_CFG_POL1])
      |=> (timing_pin_one_o == $past(half_level)))
    else $error("half-rate level not on pin one");

  a_same_source: assert property (
    (sel_zero == sel_one
     && pin_drive_config_r[`TSOM_CFG_POL0] == pin_drive_config_r[`TSOM_CFG_POL1])
      |=> (timing_pin_zero_o == timing_pin_one_o))
    else $error("same source differs between pins");

  a_pin0_logic0: assert property (
    (sel_zero == TSOM_SEL_LOGIC0) |=>
      (timing_pin_zero_o == $past(pin_drive_config_r[`TSOM_CFG_POL0])))
    else $error("pin zero not held at logic 0");

  a_pin1_od_release: assert property (
    (pin_drive_config_r[`TSOM_CFG_OD1] && !asserted_one) |=> timing_pin_one_oe_n_o)
    else $error("open drain pin one drives while idle");

  a_pin1_drive_on: assert property (
    (aux_pin_drive_enable_r[`TSOM_AUX_EN1] && !pin_drive_config_r[`TSOM_CFG_OD1])
      |=> !timing_pin_one_oe_n_o)
    else $error("push-pull pin one not driving");

  a_written_set_b: assert property (
    data_wr_b_i |=> written_b_r)
    else $error("slot B written flag not set");

  a_written_clear_a: assert property (
    (win_start && !data_wr_a_i) |=> !written_a_r)
    else $error("slot A written flag not cleared at sample start");

  a_half_standby: assert property (
    !normal_mode_i |=> !half_level)
    else $error("half-rate not low in standby");

  a_select_read: assert property (
    (reg_rd_i && reg_addr_i == `TSOM_ADDR_PIN_SELECT) |=>
      (reg_rdata_o == $past(pin_signal_select_r)))
    else $error("select register read back wrong");

  a_pin_registered: assert property (
    ($stable(asserted_zero) && $stable(pin_drive_config_r)) |=> $stable(timing_pin_zero_o))
    else $error("pin zero moved with steady source");

  c_window_cycle: cover property (
    win_start ##[1:200] win_end);

  c_both_pins_same: cover property (
    sel_zero == sel_one && sel_zero == TSOM_SEL_WR_B);

  c_half_toggle: cover property (
    normal_mode_i && sample_done ##[1:300] sample_done);

  c_open_drain_release: cover property (
    pin_drive_config_r[`TSOM_CFG_OD0] && pin_drive_config_r[`TSOM_CFG_EN0]
    && asserted_zero ##1 !asserted_zero);

endmodule

// file: tsom_pin_observer.sv
`timescale 1ns/1ps
module tsom_pin_observer (
  input wire logic pin_zero_i,
  input wire logic pin_zero_oe_n_i,
  input wire logic pin_one_i,
  input wire logic pin_one_oe_n_i,
  output logic line_zero_o,
  output logic line_one_o
);
  // host lines carry pull-ups, so a released pin reads high, never the last value
  assign line_zero_o = pin_zero_oe_n_i ? 1'b1 : pin_zero_i;
  assign line_one_o = pin_one_oe_n_i ? 1'b1 : pin_one_i;
endmodule

// file: timing_signal_output_mux_tb.sv
`timescale 1ns/1ps
`include "tsom_cfg.svh"
module timing_signal_output_mux_tb;
  import tsom_pkg::*;
  logic clock_i, resetn_i, reg_wr_i, reg_rd_i, irq_i, slot_a_en_i, slot_b_en_i;
  logic slot_a_start_i, slot_a_end_i, slot_b_start_i, slot_b_end_i, led_pulse_a_i;
  logic led_pulse_b_i, data_wr_a_i, data_wr_b_i, normal_mode_i, osc32k_i;
  logic [7:0] reg_addr_i;
  logic [15:0] reg_wdata_i, reg_rdata_o, cfg, aux, d, e;
  logic timing_pin_zero_o, timing_pin_zero_oe_n_o, timing_pin_one_o, timing_pin_one_oe_n_o;
  logic line_zero, line_one;
  logic [4:0] c0, c1;
  logic [4:0] codes [14] = '{5'h01, 5'h02, 5'h05, 5'h06, 5'h07, 5'h0C, 5'h0D, 5'h0E,
                             5'h0F, 5'h10, 5'h11, 5'h13, 5'h03, 5'h1F};
  int miscompares = 0;
  int cmp_count = 0;

  tsom_timing_mux dut (.clock_i, .resetn_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
    .reg_rd_i, .reg_rdata_o, .irq_i, .slot_a_en_i, .slot_b_en_i, .slot_a_start_i,
    .slot_a_end_i, .slot_b_start_i, .slot_b_end_i, .led_pulse_a_i, .led_pulse_b_i,
    .data_wr_a_i, .data_wr_b_i, .normal_mode_i, .osc32k_i, .timing_pin_zero_o,
    .timing_pin_zero_oe_n_o, .timing_pin_one_o, .timing_pin_one_oe_n_o);
  tsom_pin_observer host (.pin_zero_i(timing_pin_zero_o),
    .pin_zero_oe_n_i(timing_pin_zero_oe_n_o), .pin_one_i(timing_pin_one_o),
    .pin_one_oe_n_i(timing_pin_one_oe_n_o), .line_zero_o(line_zero), .line_one_o(line_one));

  initial begin
    clock_i = 1'b0;
    forever #12.5 clock_i = ~clock_i;
  end

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    #(25ns * 30000);
    miscompares++;
    $display("FAIL t=%0t watchdog expired", $time);
    tally_and_finish();
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("FAIL t=%0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] wd);
    @(negedge clock_i);
    reg_addr_i = a;
    reg_wdata_i = wd;
    reg_wr_i = 1'b1;
    @(negedge clock_i);
    reg_wr_i = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [15:0] rd_data);
    @(negedge clock_i);
    reg_addr_i = a;
    reg_rd_i = 1'b1;
    @(negedge clock_i);
    reg_rd_i = 1'b0;
    @(posedge clock_i);
    #1 rd_data = reg_rdata_o;
  endtask

  // one-cycle event pulse: 0..3 slot edges, 4/5 data stored for slot A/B
  task automatic ev(input int k);
    @(negedge clock_i);
    case (k)
      0: slot_a_start_i = 1'b1;
      1: slot_a_end_i = 1'b1;
      2: slot_b_start_i = 1'b1;
      3: slot_b_end_i = 1'b1;
      4: data_wr_a_i = 1'b1;
      default: data_wr_b_i = 1'b1;
    endcase
    @(negedge clock_i);
    {slot_a_start_i, slot_a_end_i, slot_b_start_i, slot_b_end_i} = 4'h0;
    {data_wr_a_i, data_wr_b_i} = 2'h0;
  endtask

  // {level, oe_n}: polarity after selection, open drain releases when deasserted
  function automatic logic [1:0] exp_pin(input logic v, input logic pol, input logic od,
                                         input logic en);
    return {v ^ pol, ~en | (od & ~v)};
  endfunction

  function automatic logic src(input logic [4:0] c);
    case (c)
      5'h01: return irq_i;
      5'h05: return led_pulse_a_i;
      5'h06: return led_pulse_b_i;
      5'h07: return led_pulse_a_i | led_pulse_b_i;
      5'h11: return 1'b1;
      5'h13: return osc32k_i;
      default: return 1'b0;
    endcase
  endfunction

  // three edges cover the two-cycle path from an event to the pin
  task automatic pins(input logic v0, input logic v1, input string what);
    logic [1:0] e0, e1;
    e0 = exp_pin(v0, cfg[`TSOM_CFG_POL0], cfg[`TSOM_CFG_OD0], cfg[`TSOM_CFG_EN0]);
    e1 = exp_pin(v1, cfg[`TSOM_CFG_POL1], cfg[`TSOM_CFG_OD1], aux[`TSOM_AUX_EN1]);
    repeat (3) @(posedge clock_i);
    #1;
    chk({14'h0, timing_pin_zero_o, timing_pin_zero_oe_n_o}, {14'h0, e0}, what);
    chk({14'h0, timing_pin_one_o, timing_pin_one_oe_n_o}, {14'h0, e1}, what);
    chk({15'h0, line_zero}, {15'h0, e0[0] | e0[1]}, what);
    chk({15'h0, line_one}, {15'h0, e1[0] | e1[1]}, what);
  endtask

  task automatic setup(input logic [15:0] ncfg, input logic [15:0] naux, input logic [15:0] sel);
    cfg = ncfg;
    aux = naux;
    wr(`TSOM_ADDR_PIN_DRIVE, ncfg);
    wr(`TSOM_ADDR_AUX_DRIVE, naux);
    wr(`TSOM_ADDR_PIN_SELECT, sel);
  endtask

  initial begin
    {reg_wr_i, reg_rd_i, irq_i, slot_a_en_i, slot_b_en_i, slot_a_start_i, slot_a_end_i} = 7'h00;
    {slot_b_start_i, slot_b_end_i, led_pulse_a_i, led_pulse_b_i, data_wr_a_i} = 5'h00;
    {data_wr_b_i, normal_mode_i, osc32k_i} = 3'h0;
    reg_addr_i = 8'h00;
    reg_wdata_i = 16'h0000;
    cfg = 16'h0000;
    aux = 16'h0000;
    resetn_i = 1'b0;
    repeat (12) @(negedge clock_i);
    resetn_i = 1'b1;
    void'($urandom(32'h357D));
    pins(1'b0, 1'b0, "pins after reset");
    rd(`TSOM_ADDR_PIN_DRIVE, d);
    chk(d, 16'h0000, "drive config reset");
    rd(`TSOM_ADDR_PIN_SELECT, d);
    chk(d, 16'h0000, "select reset");
    rd(`TSOM_ADDR_AUX_DRIVE, d);
    chk(d, 16'h0000, "aux reset");
    $display("test reset done");
    for (int i = 0; i < 6; i++) begin
      e = 16'($urandom());
      wr(i % 2 ? `TSOM_ADDR_PIN_SELECT : `TSOM_ADDR_AUX_DRIVE, e);
      rd(i % 2 ? `TSOM_ADDR_PIN_SELECT : `TSOM_ADDR_AUX_DRIVE, d);
      chk(d, e, "register readback");
      wr(8'h4E, e);
      rd(8'h4E, d);
      chk(d, 16'h0000, "unmapped read");
    end
    $display("test registers done");
    for (int i = 0; i < 60; i++) begin
      c0 = codes[$urandom_range(13)];
      c1 = i < 14 ? codes[i] : codes[$urandom_range(13)];
      @(negedge clock_i);
      {irq_i, led_pulse_a_i, led_pulse_b_i, osc32k_i} = 4'($urandom());
      setup(16'($urandom()), 16'($urandom()), {3'h0, c1, 3'h0, c0});
      pins(src(c0), src(c1), "static source");
    end
    $display("test static sources done");
    @(negedge clock_i);
    {irq_i, led_pulse_a_i, led_pulse_b_i, osc32k_i} = 4'h0;
    {slot_a_en_i, slot_b_en_i} = 2'h3;
    setup(16'h0204, 16'h0040, 16'h0F02);
    @(negedge clock_i);
    normal_mode_i = 1'b1;
    pins(1'b0, 1'b0, "half rate starts low");
    ev(0);
    pins(1'b1, 1'b0, "window opens at slot A");
    ev(1);
    ev(4);
    ev(2);
    pins(1'b1, 1'b0, "window spans both slots");
    ev(3);
    pins(1'b0, 1'b1, "first sample complete");
    ev(0);
    ev(1);
    ev(2);
    ev(3);
    pins(1'b0, 1'b0, "half rate second toggle");
    @(negedge clock_i);
    slot_b_en_i = 1'b0;
    ev(0);
    pins(1'b1, 1'b0, "single slot window open");
    ev(1);
    pins(1'b0, 1'b1, "single slot window close");
    @(negedge clock_i);
    normal_mode_i = 1'b0;
    pins(1'b0, 1'b0, "standby clears half rate");
    @(negedge clock_i);
    normal_mode_i = 1'b1;
    pins(1'b0, 1'b0, "restart low");
    $display("test window and half rate done");
    @(negedge clock_i);
    slot_b_en_i = 1'b1;
    wr(`TSOM_ADDR_PIN_SELECT, 16'h0E0C);
    ev(0);
    ev(1);
    ev(4);
    pins(1'b1, 1'b1, "slot A written");
    ev(2);
    ev(3);
    ev(5);
    pins(1'b1, 1'b1, "slot B written");
    ev(0);
    pins(1'b0, 1'b0, "written cleared at sample start");
    ev(1);
    ev(2);
    ev(3);
    ev(5);
    pins(1'b0, 1'b1, "only slot B written");
    wr(`TSOM_ADDR_PIN_SELECT, 16'h0D0D);
    pins(1'b1, 1'b1, "same source on both pins");
    $display("test data written done");
    tally_and_finish();
  end
endmodule
